/* pef_params.svh */
`ifndef PEF_PARAMS_SVH
`define PEF_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define PEF_OFF_ARG 5'h00
`define PEF_OFF_COEF 5'h04
`define PEF_OFF_LAST 5'h08
`define PEF_OFF_STATUS 5'h0C
`define PEF_OFF_RESULT 5'h10

// ==========================================================
// Status and control bit positions
`define PEF_STAT_BUSY 0
`define PEF_STAT_DONE 1
`define PEF_STAT_ABORT 2
`define PEF_STAT_ERR 3
`define PEF_STAT_OVF 4
`define PEF_STAT_UNFZ 5
`define PEF_CTL_TRAP 0

// ==========================================================
// Exponent handling
`define PEF_EXP_W 10
`define PEF_BIAS 10'h080
`define PEF_EXP_OVF_BIT 8
`define PEF_EXP_SIGN_BIT 9
`define PEF_ONE_EXP 10'h001

// ==========================================================
// Reset and constant values
`define PEF_ZERO_WORD 32'h0000_0000
`define PEF_ZERO_EXP 10'h000
`define PEF_ZERO_ACC 33'h0_0000_0000
`define PEF_FRAC_HALF 24'h80_0000
`define PEF_NO_ONE 6'h20
`define PEF_SHIFT_ALL 8'hFF

`endif

/* pef_pkg.sv */
package pef_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_MUL,
    ST_WAITC,
    ST_NORM,
    ST_DONE,
    ST_ABORT
  } pef_state_type;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_OVF,
    MODE_UNF
  } pef_mode_type;

  typedef struct packed {
    logic sign;
    logic [7:0] exponent;
    logic [22:0] fraction;
  } pef_float_type;

endpackage

/* pef_poly_exc.sv */
`timescale 1ns/10ps
`include "pef_params.svh"

// How it works
// [RULE1] Zero argument: wait for final coefficient, return it unless reserved.
// [RULE2] Zero first coefficient clears the accumulation, then awaits the next.
// [RULE3] Later zero coefficient: round and normalize current accumulation, wait.
// [RULE4] Reserved coefficient aborts at once and sets accelerator error.
// [RULE5] Host rejects reserved arguments and never starts on them.
// [RULE6] Overflow when exponent bit 8 high and bit 9 low.
// [RULE7] Overflow tested on raw product and on normalized sum.
// [RULE8] Normalized sum overflow sets V flag, aborts, waits for host trap.
// [RULE9] Product overflow: subtract 80 hex from accumulation exponent, recover.
// [RULE10] Overflow recovery: zero coefficient adds 80 back, normalizes, may abort.
// [RULE11] Overflow recovery: scaled coefficient underflow treated as zero.
// [RULE12] Overflow recovery: accumulation larger, shift coefficient, add, restore.
// [RULE13] Underflow when bit 9 high or bits 8 to 0 all low.
// [RULE14] Underflow sets underflow-zero bit, recovers or zeroes, never aborts.
// [RULE15] Host traps on underflow afterward only if its enable is set.
// [RULE16] Underflow tested on product and normalized sum; sum underflow zeroes.
// [RULE17] Underflow recovery: reserved aborts, zero coefficient normalizes or clears.
// [RULE18] Underflow recovery: coefficient exponent overflow makes coefficient the sum.
// [RULE19] Underflow recovery: coefficient larger, shift accumulation, add, normalize.
// [RULE20] Unrecovered underflow stores zero, pulses result and error syncs.
// [RULE21] Host marks the final coefficient with the polynomial end code.
// [RULE22] Exponent result register is ten bits wide.
module pef_poly_exc #(
  parameter int EXP_W = `PEF_EXP_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic result_ready_sync,
  output logic error_sync
);
  import pef_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Elaboration check
  if (EXP_W != `PEF_EXP_W) begin : g_bad_exp_w
    $error("EXP_W must be ten");
  end

  // ==========================================================
  // State
  pef_state_type state;
  pef_mode_type mode;
  pef_float_type arg_reg;
  pef_float_type coef;
  logic [EXP_W-1:0] exponent_result_reg; // RULE22
  logic [32:0] normalize_reg;
  logic acc_sign;
  logic last_seen;
  logic [31:0] result;
  logic accel_error;
  logic overflow_flag;
  logic underflow_zero_bit;
  logic unf_notify;
  logic rd_ack;

  // ==========================================================
  // Decode
  logic wr_ok;
  logic wr_fire;
  logic arg_take;
  logic coef_take;
  logic coef_last;
  logic trap_take;
  logic c_zero;
  logic c_rsv;
  logic arg_zero;
  logic acc_zero;
  logic [31:0] c_frac;
  logic [9:0] c_exp;

  function automatic logic is_ovf(input logic [9:0] e);
    is_ovf = e[`PEF_EXP_OVF_BIT] & ~e[`PEF_EXP_SIGN_BIT]; // RULE6
  endfunction

  function automatic logic is_unf(input logic [9:0] e);
    is_unf = e[`PEF_EXP_SIGN_BIT] | (e[8:0] == 9'h000); // RULE13
  endfunction

  assign coef = pef_float_type'(avs_writedata);
  assign c_zero = (coef.exponent == 8'h00) & ~coef.sign;
  assign c_rsv = (coef.exponent == 8'h00) & coef.sign;
  assign c_frac = {1'b1, coef.fraction, 8'h00};
  assign c_exp = {2'b00, coef.exponent};
  assign arg_zero = (arg_reg.exponent == 8'h00);
  assign acc_zero = (normalize_reg == `PEF_ZERO_ACC);
  assign coef_last = (avs_address == `PEF_OFF_LAST); // RULE21

  always_comb begin
    case (avs_address)
      `PEF_OFF_ARG, `PEF_OFF_COEF, `PEF_OFF_LAST: begin
        wr_ok = (state != ST_MUL) && (state != ST_NORM);
      end
      default: begin
        wr_ok = 1'b1;
      end
    endcase
  end

  assign avs_waitrequest = avs_read ? ~rd_ack : (avs_write & ~wr_ok);
  assign wr_fire = avs_write & wr_ok;
  assign arg_take = wr_fire && (avs_address == `PEF_OFF_ARG) &&
                    ((state == ST_IDLE) || (state == ST_DONE));
  assign coef_take = wr_fire &&
                     ((avs_address == `PEF_OFF_COEF) || coef_last) &&
                     ((state == ST_FIRST) || (state == ST_WAITC));
  assign trap_take = wr_fire && (avs_address == `PEF_OFF_STATUS) &&
                     avs_writedata[`PEF_CTL_TRAP];

  // ==========================================================
  // Multiply path
  logic [47:0] prod;
  logic [9:0] mul_exp;

  assign prod = normalize_reg[31:8] * {1'b1, arg_reg.fraction};
  assign mul_exp = exponent_result_reg + {2'b00, arg_reg.exponent} - `PEF_BIAS;

  // ==========================================================
  // Add path
  logic [9:0] a_scl;
  logic [9:0] b_scl;
  logic [9:0] res_exp;
  logic [9:0] diff;
  logic [7:0] shamt;
  logic acc_big;
  logic coef_unf;
  logic coef_ovf;
  logic [31:0] big_f;
  logic [31:0] small_f;
  logic big_s;
  logic small_s;
  logic [32:0] sum;
  logic sum_s;

  always_comb begin
    a_scl = exponent_result_reg;
    b_scl = c_exp;
    res_exp = exponent_result_reg;
    acc_big = 1'b0;
    case (mode)
      MODE_OVF: begin
        b_scl = c_exp - `PEF_BIAS; // RULE11
        acc_big = 1'b1; // RULE12
        res_exp = exponent_result_reg + `PEF_BIAS; // RULE12
      end
      MODE_UNF: begin
        a_scl = exponent_result_reg + `PEF_BIAS; // RULE18
        b_scl = c_exp + `PEF_BIAS; // RULE18
        res_exp = c_exp; // RULE19
      end
      default: begin
        acc_big = ~acc_zero && (exponent_result_reg >= c_exp);
        res_exp = acc_big ? exponent_result_reg : c_exp;
      end
    endcase
    coef_unf = is_unf(b_scl);
    coef_ovf = is_ovf(b_scl);
    diff = acc_big ? (a_scl - b_scl) : (b_scl - a_scl);
    shamt = (diff[9:8] != 2'b00) ? `PEF_SHIFT_ALL : diff[7:0];
    big_f = acc_big ? normalize_reg[31:0] : c_frac;
    small_f = (acc_big ? c_frac : normalize_reg[31:0]) >> shamt;
    big_s = acc_big ? acc_sign : coef.sign;
    small_s = acc_big ? coef.sign : acc_sign;
    if (big_s == small_s) begin
      sum = {1'b0, big_f} + {1'b0, small_f};
      sum_s = big_s;
    end else if (big_f >= small_f) begin
      sum = {1'b0, big_f - small_f};
      sum_s = big_s;
    end else begin
      sum = {1'b0, small_f - big_f};
      sum_s = small_s;
    end
  end

  // ==========================================================
  // Normalize and round
  logic [5:0] lz;
  logic [31:0] sh_frac;
  logic [9:0] e1;
  logic [9:0] e2;
  logic [24:0] rnd;
  logic [23:0] n_frac;
  logic n_ovf;
  logic n_unf;

  always_comb begin
    lz = `PEF_NO_ONE;
    for (int i = 0; i < 32; i++) begin
      if (normalize_reg[i]) begin
        lz = 6'(31 - i);
      end
    end
    if (normalize_reg[32]) begin
      sh_frac = normalize_reg[32:1];
      e1 = exponent_result_reg + `PEF_ONE_EXP;
    end else begin
      sh_frac = normalize_reg[31:0] << lz;
      e1 = exponent_result_reg - {4'h0, lz};
    end
    rnd = {1'b0, sh_frac[31:8]} + {24'h00_0000, sh_frac[7]};
    if (rnd[24]) begin
      n_frac = `PEF_FRAC_HALF;
      e2 = e1 + `PEF_ONE_EXP;
    end else begin
      n_frac = rnd[23:0];
      e2 = e1;
    end
  end

  assign n_ovf = (state == ST_NORM) && !acc_zero && is_ovf(e2); // RULE7
  assign n_unf = (state == ST_NORM) && !acc_zero && is_unf(e2); // RULE16

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else if (trap_take) begin
      state <= ST_IDLE; // RULE8
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (arg_take) begin
            state <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (coef_take) begin
            if (c_rsv) begin
              state <= ST_ABORT; // RULE4
            end else if (coef_last) begin
              state <= ST_DONE; // RULE1
            end else if (arg_zero) begin
              state <= ST_FIRST; // RULE1
            end else if (c_zero) begin
              state <= ST_WAITC; // RULE2
            end else begin
              state <= ST_MUL;
            end
          end
        end
        ST_MUL: begin
          state <= ST_WAITC;
        end
        ST_WAITC: begin
          if (coef_take) begin
            state <= c_rsv ? ST_ABORT : ST_NORM; // RULE4 RULE17
          end
        end
        ST_NORM: begin
          if (n_ovf) begin
            state <= ST_ABORT; // RULE8 RULE10
          end else if (last_seen) begin
            state <= ST_DONE;
          end else begin
            state <= ST_MUL; // RULE14
          end
        end
        ST_ABORT: begin
          state <= ST_ABORT;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Accumulation data path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arg_reg <= pef_float_type'(`PEF_ZERO_WORD);
      mode <= MODE_NORMAL;
      exponent_result_reg <= `PEF_ZERO_EXP;
      normalize_reg <= `PEF_ZERO_ACC;
      acc_sign <= 1'b0;
      last_seen <= 1'b0;
      result <= `PEF_ZERO_WORD;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (arg_take) begin
            arg_reg <= coef; // RULE5
            mode <= MODE_NORMAL;
            last_seen <= 1'b0;
          end
        end
        ST_FIRST: begin
          if (coef_take && !c_rsv) begin
            if (coef_last) begin
              result <= avs_writedata; // RULE1
            end else if (c_zero) begin
              normalize_reg <= `PEF_ZERO_ACC; // RULE2
              exponent_result_reg <= `PEF_ZERO_EXP; // RULE2
              acc_sign <= 1'b0;
            end else begin
              normalize_reg <= {1'b0, c_frac};
              exponent_result_reg <= c_exp;
              acc_sign <= coef.sign;
            end
          end
        end
        ST_MUL: begin
          mode <= MODE_NORMAL;
          if (acc_zero) begin
            exponent_result_reg <= `PEF_ZERO_EXP;
          end else begin
            normalize_reg <= {1'b0, prod[47:16]};
            acc_sign <= acc_sign ^ arg_reg.sign;
            if (is_ovf(mul_exp)) begin // RULE7
              mode <= MODE_OVF;
              exponent_result_reg <= mul_exp - `PEF_BIAS; // RULE9
            end else begin
              mode <= is_unf(mul_exp) ? MODE_UNF : MODE_NORMAL; // RULE16
              exponent_result_reg <= mul_exp;
            end
          end
        end
        ST_WAITC: begin
          if (coef_take && !c_rsv) begin
            last_seen <= coef_last;
            if (c_zero || ((mode == MODE_OVF) && coef_unf)) begin
              if (mode == MODE_OVF) begin
                exponent_result_reg <= exponent_result_reg + `PEF_BIAS; // RULE10 RULE11
              end
            end else if ((mode == MODE_UNF) && coef_ovf) begin
              normalize_reg <= {1'b0, c_frac}; // RULE18
              exponent_result_reg <= c_exp; // RULE18
              acc_sign <= coef.sign;
            end else begin
              normalize_reg <= sum; // RULE12 RULE19
              exponent_result_reg <= res_exp;
              acc_sign <= sum_s;
            end
          end
        end
        ST_NORM: begin
          if (acc_zero || n_unf) begin
            normalize_reg <= `PEF_ZERO_ACC; // RULE14 RULE17 RULE20
            exponent_result_reg <= `PEF_ZERO_EXP;
            acc_sign <= 1'b0;
            if (last_seen) begin
              result <= `PEF_ZERO_WORD;
            end
          end else begin
            normalize_reg <= {1'b0, n_frac, 8'h00}; // RULE3
            exponent_result_reg <= e2;
            if (last_seen) begin
              result <= {acc_sign, e2[7:0], n_frac[22:0]};
            end
          end
        end
        default: begin
          mode <= mode;
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags, set wins over clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accel_error <= 1'b0;
      overflow_flag <= 1'b0;
      underflow_zero_bit <= 1'b0;
      unf_notify <= 1'b0;
    end else begin
      accel_error <= (accel_error & ~arg_take) | (coef_take & c_rsv) |
                     n_ovf; // RULE4
      overflow_flag <= (overflow_flag & ~arg_take) | n_ovf; // RULE8
      underflow_zero_bit <= (underflow_zero_bit & ~arg_take) | n_unf |
                            ((state == ST_MUL) && !acc_zero &&
                             !is_ovf(mul_exp) && is_unf(mul_exp)); // RULE14
      unf_notify <= n_unf; // RULE20
    end
  end

  assign result_ready_sync = (state == ST_DONE) | unf_notify; // RULE20
  assign error_sync = accel_error | unf_notify; // RULE20

  // ==========================================================
  // Register read port
  logic [31:0] stat_word;

  always_comb begin
    stat_word = `PEF_ZERO_WORD;
    stat_word[`PEF_STAT_BUSY] = (state != ST_IDLE) && (state != ST_DONE) &&
                                (state != ST_ABORT);
    stat_word[`PEF_STAT_DONE] = (state == ST_DONE);
    stat_word[`PEF_STAT_ABORT] = (state == ST_ABORT);
    stat_word[`PEF_STAT_ERR] = accel_error;
    stat_word[`PEF_STAT_OVF] = overflow_flag;
    stat_word[`PEF_STAT_UNFZ] = underflow_zero_bit;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ack <= 1'b0;
      avs_readdata <= `PEF_ZERO_WORD;
    end else begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read && !rd_ack) begin
        case (avs_address)
          `PEF_OFF_STATUS: avs_readdata <= stat_word;
          `PEF_OFF_RESULT: avs_readdata <= result;
          `PEF_OFF_ARG: avs_readdata <= arg_reg;
          default: avs_readdata <= `PEF_ZERO_WORD;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  sequence s_norm_unf;
    (state == ST_NORM) && !acc_zero && is_unf(e2);
  endsequence

  sequence s_zero_notified;
    (normalize_reg == `PEF_ZERO_ACC) && underflow_zero_bit &&
    result_ready_sync && error_sync;
  endsequence

  property p_rsv_abort;
    coef_take && c_rsv |=> (state == ST_ABORT) && accel_error;
  endproperty
  a_rsv_abort: assert property (p_rsv_abort) // RULE4
    else $error("reserved coefficient did not abort");

  property p_arg_zero_wait;
    (state == ST_FIRST) && arg_zero && coef_take && !coef_last && !c_rsv
      |=> (state == ST_FIRST);
  endproperty
  a_arg_zero_wait: assert property (p_arg_zero_wait) // RULE1
    else $error("zero argument left the first loop");

  property p_first_last;
    (state == ST_FIRST) && coef_take && coef_last && !c_rsv
      |=> (state == ST_DONE) && (result == $past(avs_writedata));
  endproperty
  a_first_last: assert property (p_first_last) // RULE1
    else $error("final coefficient not returned unchanged");

  property p_first_zero;
    (state == ST_FIRST) && coef_take && c_zero && !arg_zero && !coef_last
      |=> acc_zero && (state == ST_WAITC);
  endproperty
  a_first_zero: assert property (p_first_zero) // RULE2
    else $error("zero first coefficient did not clear");

  property p_norm_ovf;
    (state == ST_NORM) && !acc_zero && is_ovf(e2)
      |=> (state == ST_ABORT) && overflow_flag && error_sync;
  endproperty
  a_norm_ovf: assert property (p_norm_ovf) // RULE8
    else $error("normalized overflow did not abort");

  property p_norm_unf;
    s_norm_unf |=> s_zero_notified ##1 (state != ST_ABORT);
  endproperty
  a_norm_unf: assert property (p_norm_unf) // RULE20
    else $error("normalized underflow not zeroed and reported");

  property p_mul_ovf;
    (state == ST_MUL) && !acc_zero && is_ovf(mul_exp)
      |=> (mode == MODE_OVF) &&
          (exponent_result_reg == $past(mul_exp) - `PEF_BIAS);
  endproperty
  a_mul_ovf: assert property (p_mul_ovf) // RULE9
    else $error("product overflow not scaled down");

  property p_ovf_zero;
    (state == ST_WAITC) && (mode == MODE_OVF) && coef_take && c_zero
      |=> (exponent_result_reg == $past(exponent_result_reg) + `PEF_BIAS)
          ##1 (state != ST_WAITC);
  endproperty
  a_ovf_zero: assert property (p_ovf_zero) // RULE10
    else $error("overflow recovery did not restore exponent");

  property p_unf_take_coef;
    (state == ST_WAITC) && (mode == MODE_UNF) && coef_take && !c_zero &&
      !c_rsv && coef_ovf
      |=> (normalize_reg == {1'b0, $past(c_frac)}) &&
          (exponent_result_reg == $past(c_exp));
  endproperty
  a_unf_take_coef: assert property (p_unf_take_coef) // RULE18
    else $error("large coefficient did not replace accumulation");

endmodule

/* pef_host_model.sv */
`timescale 1ns/10ps
`include "pef_params.svh"

// ==========================================================
// Host side: bus master sending operands and traps
module pef_host_model (
  input wire logic sys_clk,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  logic [31:0] processor_status_word;
  logic underflow_trap;

  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    processor_status_word = 32'h0000_0000;
    underflow_trap = 1'b0;
  end

  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // ==========================================================
  // Operand and trap handling
  task automatic start(input logic [31:0] arg, output logic started);
    started = !(arg[31] === 1'b1 && arg[30:23] === 8'h00);
    if (started) begin
      wr(`PEF_OFF_ARG, arg);
    end
  endtask

  task automatic last_coef(input logic [31:0] c);
    wr(`PEF_OFF_LAST, c);
  endtask

  task automatic trap();
    wr(`PEF_OFF_STATUS, 32'h0000_0001);
  endtask

  task automatic finish(input logic [31:0] st);
    underflow_trap = processor_status_word[6] & st[`PEF_STAT_UNFZ];
  endtask
endmodule

/* polynomial_exception_flow_bench.sv */
`timescale 1ns/10ps
`include "pef_params.svh"

// ==========================================================
// Bench top
module polynomial_exception_flow_bench;
  localparam logic [31:0] k_zero = 32'h0000_0000;
  localparam logic [31:0] k_one = 32'h4080_0000;
  localparam logic [31:0] k_two = 32'h4100_0000;
  localparam logic [31:0] k_max = 32'h7F80_0000;
  localparam logic [31:0] k_rsv = 32'h8000_0000;
  logic sys_clk;
  logic resetn;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic result_ready_sync;
  logic error_sync;
  int n_fail = 0;
  int samples_checked = 0;
  int n_both = 0;
  int b;
  logic ok;
  logic [31:0] rdata;
  logic [31:0] ovf_last [0:2] = '{32'h0000_0000, 32'h4080_0000, 32'h3F80_0000};
  logic [31:0] unf_last [0:2] = '{32'h0000_0000, 32'h7F80_0000, 32'h0100_0000};

  pef_poly_exc #(.EXP_W(`PEF_EXP_W)) dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .result_ready_sync(result_ready_sync),
    .error_sync(error_sync)
  );

  pef_host_model host (
    .sys_clk(sys_clk),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Counts cycles with both syncs high
  always @(posedge sys_clk) begin
    if (result_ready_sync === 1'b1 && error_sync === 1'b1) begin
      n_both <= n_both + 1;
    end
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
          exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // One polynomial: trap, argument, coefficients, final, compare
  task automatic op(input logic [31:0] arg, input int n,
      input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] last,
      input logic [5:0] st, input logic [31:0] res);
    logic [31:0] s;
    int k;
    host.trap();
    host.start(arg, ok);
    if (n > 0) begin
      host.wr(`PEF_OFF_COEF, c0);
    end
    if (n > 1) begin
      host.wr(`PEF_OFF_COEF, c1);
    end
    host.last_coef(last);
    k = 0;
    s = 32'h0000_0001;
    while (s[`PEF_STAT_DONE] !== 1'b1 && s[`PEF_STAT_ABORT] !== 1'b1
        && k < 40) begin
      host.rd(`PEF_OFF_STATUS, s);
      k++;
    end
    check(s, {26'h0, st}, "status");
    if (st[`PEF_STAT_DONE]) begin
      host.rd(`PEF_OFF_RESULT, s);
      check(s, res, "result");
      check({31'h0, result_ready_sync}, 32'h1, "ready sync");
    end
    $display("test done: arg %h last %h", arg, last);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("mismatch at %0t: timeout", $time);
    summarize();
  end

  // ==========================================================
  // Test sequence
  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    host.rd(`PEF_OFF_STATUS, rdata);
    check(rdata, k_zero, "status after reset");
    host.rd(5'h14, rdata);
    check(rdata, k_zero, "unmapped read");
    op(k_one, 0, k_zero, k_zero, 32'h4140_0000, 6'h02, 32'h4140_0000);
    host.rd(`PEF_OFF_ARG, rdata);
    check(rdata, k_one, "argument readback");
    op(k_zero, 2, k_one, k_two, 32'h40C0_0000, 6'h02, 32'h40C0_0000);
    op(k_zero, 0, k_zero, k_zero, k_rsv, 6'h0C, k_zero);
    check({31'h0, error_sync}, 32'h1, "error sync level");
    op(k_one, 2, k_rsv, k_zero, k_one, 6'h0C, k_zero);
    op(k_one, 1, k_one, k_zero, k_one, 6'h02, k_two);
    op(k_one, 1, k_zero, k_zero, k_one, 6'h02, k_one);
    op(k_one, 2, k_one, k_zero, k_one, 6'h02, k_two);
    op(32'h4000_0000, 1, 32'h7FC0_0000, k_zero, 32'h7FC0_0000, 6'h1C,
        k_zero);
    check({31'h0, error_sync}, 32'h1, "overflow error sync");
    op(k_max, 1, k_max, k_zero, k_zero, 6'h1C, k_zero);
    for (int i = 0; i < 3; i++) begin
      op(k_one, 1, k_max, k_zero, ovf_last[i], 6'h02, k_max);
    end
    for (int i = 0; i < 3; i++) begin
      op(32'h0080_0000, 1, 32'h0080_0000, k_zero, unf_last[i], 6'h22,
          unf_last[i]);
    end
    b = n_both;
    op(k_one, 2, 32'h0080_0000, 32'h80A0_0000, k_one, 6'h22, k_one);
    check({31'h0, n_both > b}, 32'h1, "both syncs pulse");
    host.processor_status_word = 32'h0000_0040;
    host.rd(`PEF_OFF_STATUS, rdata);
    host.finish(rdata);
    check({31'h0, host.underflow_trap}, 32'h1, "underflow trap");
    host.trap();
    host.start(k_rsv, ok);
    check({31'h0, ok}, k_zero, "reserved argument");
    summarize();
  end
endmodule
